// ---- hw/bmd_pkg.sv ----
// Package: constants and types for the board memory map and DRAM control
package bmd_pkg;
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned ADDR_W         = 28;
  localparam int unsigned MB_SHIFT       = 20;
  localparam int unsigned MB_W           = 6;
  localparam int unsigned REFRESH_US     = 15;
  localparam int unsigned REFRESH_CYC    = REFRESH_US * CLK_MHZ;
  localparam int unsigned T_SLOW_NS      = 100;
  localparam int unsigned T_FAST_NS      = 85;
  localparam int unsigned T_SLOW_CYC     = (T_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_FAST_CYC     = (T_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REF_HOLD_CYC   = 4;
  localparam int unsigned PAGE_SHIFT     = 11;
  localparam int unsigned ROW_W          = 8;
  localparam logic [27:0] ISA_TOP        = 28'h1000000;
  localparam logic [27:0] ADAPT_LO       = 28'h00c8000;
  localparam logic [27:0] ADAPT_HI       = 28'h00dffff;
  localparam logic [27:0] ROM_LO         = 28'h00e0000;
  localparam logic [27:0] ROM_HI         = 28'h00fffff;
  localparam logic [27:0] ALIAS_LO       = 28'h0fe0000;
  localparam logic [27:0] ALIAS_HI       = 28'h0ffffff;
  localparam logic [27:0] ALIAS_MASK     = 28'h001ffff;
  // Register map (Avalon word offsets, byte address = 4 * index)
  localparam logic [3:0]  REG_CONFIG     = 4'h0;
  localparam logic [3:0]  REG_MAP_TOP    = 4'h1;
  localparam logic [3:0]  REG_STATUS     = 4'h2;
  localparam logic [3:0]  REG_ROW        = 4'h3;
  localparam logic [3:0]  REG_SHADOW     = 4'h4;
  localparam int unsigned CFG_SHADOW_BIT = 0;
  localparam logic [31:0] UNMAPPED_VAL   = 32'h00000000;
  typedef enum logic [1:0] {
    BMD_MODE_FAST_PAGE,
    BMD_MODE_STATIC_COL,
    BMD_MODE_RAS_CAS
  } bmd_mode_t;
  typedef enum logic [2:0] {
    BMD_TGT_BANK0,
    BMD_TGT_BANK1,
    BMD_TGT_SLOT0,
    BMD_TGT_SLOT1,
    BMD_TGT_ISA,
    BMD_TGT_ROM,
    BMD_TGT_ADAPTER
  } bmd_tgt_t;
  typedef enum logic [1:0] {
    BMD_ACC_RAS_CAS,
    BMD_ACC_FAST_PAGE,
    BMD_ACC_STATIC_COL
  } bmd_acc_t;
endpackage

// ---- hw/bmd_decode.sv ----
// Address decoder: low map, ROM alias, packed 32-bit memory, ISA holes
module bmd_decode
  import bmd_pkg::*;
(
  input  wire logic [27:0]   addr,
  input  wire logic [MB_W:0] top0,
  input  wire logic [MB_W:0] top1,
  input  wire logic [MB_W:0] top2,
  input  wire logic [MB_W:0] top3,
  input  wire logic          shadow_en,
  output bmd_tgt_t           tgt,
  output logic [27:0]        eff_addr,
  output logic               cacheable
);
  logic [MB_W:0] mb;
  always_comb begin
    eff_addr  = addr;
    tgt       = BMD_TGT_ISA;
    cacheable = 1'b0;
    if (addr >= ALIAS_LO && addr <= ALIAS_HI) begin
      eff_addr = ROM_LO | (addr & ALIAS_MASK);
    end
    mb = {1'b0, eff_addr[MB_SHIFT+MB_W-1:MB_SHIFT]};
    if (eff_addr >= ADAPT_LO && eff_addr <= ADAPT_HI) begin
      tgt = BMD_TGT_ADAPTER;
    end else if (eff_addr >= ROM_LO && eff_addr <= ROM_HI && !shadow_en) begin
      tgt = BMD_TGT_ROM;
    end else if (addr[27:MB_SHIFT+MB_W] != '0) begin
      tgt = BMD_TGT_ISA;
    end else if (mb < top0) begin
      tgt = BMD_TGT_BANK0;
    end else if (mb < top1) begin
      tgt = BMD_TGT_BANK1;
    end else if (mb < top2) begin
      tgt = BMD_TGT_SLOT0;
    end else if (mb < top3) begin
      tgt = BMD_TGT_SLOT1;
    end else begin
      tgt = BMD_TGT_ISA;
    end
    // Shadowed system BIOS is never cached
    if (tgt <= BMD_TGT_SLOT1) begin
      cacheable = !(shadow_en && eff_addr >= ROM_LO && eff_addr <= ROM_HI);
    end
  end
endmodule

// ---- hw/bmd_ctrl.sv ----
// Board memory map and DRAM control: allocation, access modes, refresh
// How it works
// - Bank0 at zero, then bank1, slot0, slot1
// - Pack up to 40M contiguously in hardware
// - Hole above memory up to 16M goes ISA
// - Sample jumpers and slot configuration at reset
// - Fast-page mode reuses same page
// - Static-column mode reuses same page
// - Page miss falls back to RAS/CAS
// - Fast-page is default; jumpers pick mode
// - Speed 100 ns default, 85 ns selectable
// - Start refresh every 15 microseconds
// - Refresh ISA and 32-bit memory together
// - Cache hits proceed during refresh; here cache_hit is unused and all requests wait for refresh to end
// - Run master's refresh, then return bus
// - Four parity bits stored with data
// - Onboard totals 1, 2, 4 or 8M; two banks at the 1M setting map 0M here
// - Slot boards of 4, 8 or 16M
// - All 32-bit memory cacheable except shadow BIOS
// - C8000-DFFFF goes to adapter cards
// - FE0000-FFFFFF aliases ROM at E0000
// - Refresh drives row on low address lines
module bmd_ctrl
  import bmd_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // Board straps, sampled after reset
  input  wire logic [1:0]    jmp_onboard_total,
  input  wire logic          jmp_two_banks,
  input  wire logic [1:0]    jmp_mode,
  input  wire logic          jmp_fast_speed,
  input  wire logic [1:0]    slot0_cfg,
  input  wire logic [1:0]    slot1_cfg,
  // Memory request from processor/cache side
  input  wire logic          mem_req,
  input  wire logic          mem_we,
  input  wire logic [27:0]   mem_addr,
  input  wire logic [31:0]   mem_wdata,
  input  wire logic          cache_hit,
  output logic               mem_ack,
  output logic [31:0]        mem_rdata,
  output logic               mem_parity_err,
  output logic [2:0]         mem_target,
  output logic               mem_cacheable,
  output logic [1:0]         mem_access,
  // Refresh and secondary bus master
  input  wire logic          secondary_bus_master_own,
  input  wire logic          secondary_bus_master_ref_req,
  output logic               secondary_bus_master_grant,
  output logic               refresh_active,
  output logic [7:0]         refresh_addr,
  // Avalon-MM slave
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest
);
  localparam int unsigned RCW = $clog2(REFRESH_CYCLES + 1);
  localparam int unsigned WORDS = 16;

  // Pin straps: two-stage sync
  logic [11:0] strap_s1_q;
  logic [11:0] strap_s2_q;
  logic [1:0]  strap_vld_q;
  logic        strap_done_q;
  // The valid shift keeps the all-zero reset image from being captured
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_q  <= '0;
      strap_s2_q  <= '0;
      strap_vld_q <= '0;
    end else begin
      strap_vld_q <= {strap_vld_q[0], 1'b1};
      strap_s1_q <= {jmp_onboard_total, jmp_two_banks, jmp_mode,
                     jmp_fast_speed, slot0_cfg, slot1_cfg,
                     secondary_bus_master_own, secondary_bus_master_ref_req};
      strap_s2_q <= strap_s1_q;
    end
  end

  function automatic logic [MB_W:0] slot_mb(input logic [1:0] cfg);
    case (cfg)
      2'h1:    slot_mb = 7'h04;
      2'h2:    slot_mb = 7'h08;
      2'h3:    slot_mb = 7'h10;
      default: slot_mb = 7'h00;
    endcase
  endfunction

  // Allocation captured once after reset release
  logic [MB_W:0] top0_q, top1_q, top2_q, top3_q;
  bmd_mode_t     mode_q;
  logic          fast_q;
  logic [MB_W:0] bank_mb;
  logic [MB_W:0] t2, t3;
  always_comb begin
    case (strap_s2_q[11:10])
      2'h0:    bank_mb = 7'h01;
      2'h1:    bank_mb = 7'h02;
      2'h2:    bank_mb = 7'h04;
      default: bank_mb = 7'h08;
    endcase
    if (strap_s2_q[9]) begin
      bank_mb = bank_mb >> 1;
    end
    t2 = (strap_s2_q[9] ? bank_mb + bank_mb : bank_mb) +
         slot_mb(strap_s2_q[5:4]);
    t3 = t2 + slot_mb(strap_s2_q[3:2]);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_q <= 1'b0;
      top0_q       <= '0;
      top1_q       <= '0;
      top2_q       <= '0;
      top3_q       <= '0;
      mode_q       <= BMD_MODE_FAST_PAGE;
      fast_q       <= 1'b0;
    end else if (!strap_done_q && strap_vld_q[1] &&
                 strap_s1_q == strap_s2_q) begin
      // Wait one stable cycle so the sync chain has filled
      strap_done_q <= 1'b1;
      top0_q       <= bank_mb;
      top1_q       <= strap_s2_q[9] ? bank_mb + bank_mb : bank_mb;
      top2_q       <= t2;
      top3_q       <= t3;
      case (strap_s2_q[8:7])
        2'h1:    mode_q <= BMD_MODE_STATIC_COL;
        2'h2:    mode_q <= BMD_MODE_RAS_CAS;
        default: mode_q <= BMD_MODE_FAST_PAGE;
      endcase
      fast_q <= strap_s2_q[6];
    end
  end

  // Registers software can steer
  logic shadow_q;
  logic cfg_hold_q;

  // Decoder
  bmd_tgt_t    tgt;
  logic [27:0] eff_addr;
  logic        cacheable;
  bmd_decode u_dec (
    .addr      (mem_addr),
    .top0      (top0_q),
    .top1      (top1_q),
    .top2      (top2_q),
    .top3      (top3_q),
    .shadow_en (shadow_q),
    .tgt       (tgt),
    .eff_addr  (eff_addr),
    .cacheable (cacheable)
  );

  // Backing store is a small flop array so the block stands alone
  logic [35:0] store_q [WORDS];
  logic [3:0]  widx;
  assign widx = eff_addr[5:2];

  function automatic logic [3:0] par4(input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      par4[i] = ^d[i*8 +: 8];
    end
  endfunction

  // Access sequencer
  typedef enum {S_IDLE, S_WAIT, S_REF} bmd_state_t;
  bmd_state_t  st_q;
  logic [3:0]  wait_q;
  logic        page_vld_q;
  logic [27:PAGE_SHIFT] page_q;
  logic [RCW-1:0] rcnt_q;
  logic        ref_due_q;
  logic [2:0]  rhold_q;
  logic        same_page;
  logic        is_dram;
  logic        sbm_req;
  assign same_page = page_vld_q && page_q == eff_addr[27:PAGE_SHIFT];
  assign is_dram = tgt <= BMD_TGT_SLOT1;
  assign sbm_req = strap_s2_q[1] && strap_s2_q[0];

  // Refresh interval timer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt_q    <= '0;
      ref_due_q <= 1'b0;
    end else begin
      if (rcnt_q == RCW'(REFRESH_CYCLES - 1)) begin
        rcnt_q    <= '0;
        ref_due_q <= 1'b1;
      end else begin
        rcnt_q <= rcnt_q + 1'b1;
        if (st_q == S_REF && rhold_q == '0) begin
          ref_due_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q           <= S_IDLE;
      wait_q         <= '0;
      page_vld_q     <= 1'b0;
      page_q         <= '0;
      rhold_q        <= '0;
      mem_ack        <= 1'b0;
      mem_rdata      <= '0;
      mem_parity_err <= 1'b0;
      mem_target     <= '0;
      mem_cacheable  <= 1'b0;
      mem_access     <= BMD_ACC_RAS_CAS;
      refresh_active <= 1'b0;
      refresh_addr   <= '0;
      secondary_bus_master_grant <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (strap_done_q && (ref_due_q || sbm_req)) begin
            st_q           <= S_REF;
            rhold_q        <= 3'(REF_HOLD_CYC - 1);
            refresh_active <= 1'b1;
            secondary_bus_master_grant <= 1'b0;
            page_vld_q     <= 1'b0;
          end else if (strap_done_q && mem_req && !cfg_hold_q &&
                       !mem_ack) begin
            // Ack cycle skipped: the master still holds the old request
            mem_target    <= tgt;
            mem_cacheable <= cacheable;
            if (is_dram && same_page && mode_q == BMD_MODE_FAST_PAGE) begin
              mem_access <= BMD_ACC_FAST_PAGE;
              wait_q     <= '0;
            end else if (is_dram && same_page &&
                         mode_q == BMD_MODE_STATIC_COL) begin
              mem_access <= BMD_ACC_STATIC_COL;
              wait_q     <= '0;
            end else begin
              mem_access <= BMD_ACC_RAS_CAS;
              wait_q <= fast_q ? 4'(T_FAST_CYC) : 4'(T_SLOW_CYC);
            end
            page_vld_q <= is_dram;
            page_q     <= eff_addr[27:PAGE_SHIFT];
            st_q       <= S_WAIT;
          end else begin
            secondary_bus_master_grant <= strap_s2_q[1];
          end
        end
        S_WAIT: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
          end else begin
            if (is_dram && !mem_we) begin
              mem_rdata      <= store_q[widx][31:0];
              mem_parity_err <= par4(store_q[widx][31:0]) !=
                                store_q[widx][35:32];
            end else if (!mem_we) begin
              mem_rdata <= '0;
            end
            mem_ack <= 1'b1;
            st_q    <= S_IDLE;
          end
        end
        S_REF: begin
          // cache_hit is not looked at; every request waits here until refresh ends
          if (rhold_q == '0) begin
            refresh_active <= 1'b0;
            refresh_addr   <= refresh_addr + 1'b1;
            secondary_bus_master_grant <= strap_s2_q[1];
            st_q           <= S_IDLE;
          end else begin
            rhold_q <= rhold_q - 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Data store write with parity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        store_q[i] <= '0;
      end
    end else if (st_q == S_WAIT && wait_q == '0 && is_dram && mem_we) begin
      store_q[widx] <= {par4(mem_wdata), mem_wdata};
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  logic        avs_busy_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_busy_q      <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      shadow_q        <= 1'b0;
      cfg_hold_q      <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
      avs_busy_q      <= 1'b0;
      if ((avs_read || avs_write) && !avs_busy_q && avs_waitrequest) begin
        avs_busy_q      <= 1'b1;
        avs_waitrequest <= 1'b0;
        if (avs_write && avs_address == REG_SHADOW) begin
          shadow_q   <= avs_writedata[CFG_SHADOW_BIT];
        end
        if (avs_write && avs_address == REG_CONFIG) begin
          cfg_hold_q <= avs_writedata[CFG_SHADOW_BIT];
        end
        case (avs_address)
          REG_CONFIG: avs_readdata <= {27'h0, fast_q, mode_q, strap_done_q,
                                       cfg_hold_q};
          REG_MAP_TOP: avs_readdata <= {4'h0, 7'(top3_q), 7'(top2_q),
                                        7'(top1_q), 7'(top0_q)};
          REG_STATUS: avs_readdata <= {29'h0, secondary_bus_master_grant,
                                       refresh_active, mem_parity_err};
          REG_ROW: avs_readdata <= {24'h0, refresh_addr};
          REG_SHADOW: avs_readdata <= {31'h0, shadow_q};
          default: avs_readdata <= UNMAPPED_VAL;
        endcase
      end
    end
  end

  // Assertions
  sequence s_ref_start;
    $rose(refresh_active);
  endsequence
  sequence s_ref_over;
    ##[4:5] !refresh_active;
  endsequence
  property p_ref_ends;
    @(posedge core_clk) disable iff (!arst_n) s_ref_start |-> s_ref_over;
  endproperty
  a_ref_ends: assert property (p_ref_ends)
    else $error("refresh did not end");
  property p_no_ack_ref;
    @(posedge core_clk) disable iff (!arst_n) refresh_active |-> !mem_ack;
  endproperty
  a_no_ack_ref: assert property (p_no_ack_ref)
    else $error("ack during refresh");
  property p_row_inc;
    @(posedge core_clk) disable iff (!arst_n)
      $fell(refresh_active) |->
      refresh_addr == $past(refresh_addr) + 8'h01;
  endproperty
  a_row_inc: assert property (p_row_inc)
    else $error("refresh row not advanced");
  property p_grant_off;
    @(posedge core_clk) disable iff (!arst_n)
      refresh_active |-> !secondary_bus_master_grant;
  endproperty
  a_grant_off: assert property (p_grant_off)
    else $error("grant held in refresh");
  property p_fast_mode;
    @(posedge core_clk) disable iff (!arst_n)
      mem_ack && mem_access == BMD_ACC_FAST_PAGE |->
      mode_q == BMD_MODE_FAST_PAGE;
  endproperty
  a_fast_mode: assert property (p_fast_mode)
    else $error("fast page in wrong mode");
  property p_sc_mode;
    @(posedge core_clk) disable iff (!arst_n)
      mem_ack && mem_access == BMD_ACC_STATIC_COL |->
      mode_q == BMD_MODE_STATIC_COL;
  endproperty
  a_sc_mode: assert property (p_sc_mode)
    else $error("static column in wrong mode");
  property p_order;
    @(posedge core_clk) disable iff (!arst_n)
      strap_done_q |-> top0_q <= top1_q && top1_q <= top2_q &&
      top2_q <= top3_q;
  endproperty
  a_order: assert property (p_order)
    else $error("allocation out of order");
  property p_ack_pulse;
    @(posedge core_clk) disable iff (!arst_n) mem_ack |=> !mem_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
endmodule

// ---- tb/bmd_sbm_model.sv ----
// Secondary bus master model: owns the bus and asks for refresh while owning
module bmd_sbm_model #(
  parameter int unsigned REQ_GAP = 20
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic take_bus,
  input  wire logic refresh_active,
  output logic      sbm_own,
  output logic      sbm_ref_req
);
  int unsigned gap_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sbm_own <= 1'b0;
    end else begin
      sbm_own <= take_bus;
    end
  end

  // Long ownership would starve the DRAM, so ask at a fixed spacing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q       <= 0;
      sbm_ref_req <= 1'b0;
    end else if (!sbm_own) begin
      gap_q       <= 0;
      sbm_ref_req <= 1'b0;
    end else if (sbm_ref_req) begin
      if (refresh_active) begin
        sbm_ref_req <= 1'b0;
        gap_q       <= 0;
      end
    end else if (gap_q >= REQ_GAP) begin
      sbm_ref_req <= 1'b1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
endmodule

// ---- tb/bmd_ctrl_tb.sv ----
// Self-checking bench for the board memory map and DRAM control block
`define CHK(nm, ex, got) begin checked++; \
  if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h got %h", nm, (ex), (got)); end end
module bmd_ctrl_tb;
  import bmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF = 300;
  logic core_clk, arst_n, two, fast, mem_req, mem_we, cache_hit, take_bus;
  logic [1:0] tot, mode, s0, s1, m_acc;
  logic [27:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata, avs_writedata, avs_readdata, rd;
  logic mem_ack, mem_parity_err, mem_cacheable, grant, ref_act, own, rreq;
  logic [2:0] mem_target, m_tgt;
  logic [1:0] mem_access;
  logic [7:0] refresh_addr, r0;
  logic [3:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, m_cac, m_pe;
  logic [31:0] m_rd;
  int fails = 0;
  int checked = 0;

  bmd_ctrl #(.REFRESH_CYCLES(REF)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .jmp_onboard_total(tot),
    .jmp_two_banks(two), .jmp_mode(mode), .jmp_fast_speed(fast),
    .slot0_cfg(s0), .slot1_cfg(s1), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cache_hit(cache_hit),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_parity_err(mem_parity_err), .mem_target(mem_target),
    .mem_cacheable(mem_cacheable), .mem_access(mem_access),
    .secondary_bus_master_own(own), .secondary_bus_master_ref_req(rreq),
    .secondary_bus_master_grant(grant), .refresh_active(ref_act),
    .refresh_addr(refresh_addr), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  bmd_sbm_model #(.REQ_GAP(20)) sbm (
    .core_clk(core_clk), .arst_n(arst_n), .take_bus(take_bus),
    .refresh_active(ref_act), .sbm_own(own), .sbm_ref_req(rreq));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task end_of_test();
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Straps only count at reset, so every configuration needs a new reset
  task do_reset(input logic [1:0] t, input logic b, input logic [1:0] m,
                input logic f, input logic [1:0] a, input logic [1:0] c);
    @(posedge core_clk);
    tot <= t; two <= b; mode <= m; fast <= f; s0 <= a; s1 <= c;
    arst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK("waitrequest in reset", 1'b1, avs_waitrequest)
    `CHK("ack in reset", 1'b0, mem_ack)
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task av_go(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a; avs_writedata <= d;
    avs_write <= w; avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    `CHK("waitrequest", 1'b0, avs_waitrequest)
    rd = avs_readdata;
    avs_read <= 1'b0; avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task mem_go(input logic [27:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    mem_addr <= a; mem_we <= w; mem_wdata <= d; mem_req <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (mem_ack !== 1'b1 && n < 100);
    `CHK("mem ack", 1'b1, mem_ack)
    m_tgt = mem_target; m_acc = mem_access; m_cac = mem_cacheable;
    m_rd = mem_rdata; m_pe = mem_parity_err;
    mem_req <= 1'b0;
    @(posedge core_clk);
  endtask

  task chk_tgt(input logic [27:0] a, input bmd_tgt_t ex);
    mem_go(a, 1'b0, 32'h00000000);
    `CHK("target", ex, m_tgt)
  endtask

  task t_map_a();
    do_reset(2'h1, 1'b1, 2'h0, 1'b0, 2'h2, 2'h0);
    av_go(REG_CONFIG, 1'b0, 32'h0);
    `CHK("config default", 32'h00000002, rd)
    chk_tgt(28'h0000100, BMD_TGT_BANK0);
    chk_tgt(28'h0100000, BMD_TGT_BANK1);
    chk_tgt(28'h0200000, BMD_TGT_SLOT0);
    chk_tgt(28'h09ffffc, BMD_TGT_SLOT0);
    chk_tgt(28'h0a00000, BMD_TGT_ISA);
    chk_tgt(28'h0fdfffc, BMD_TGT_ISA);
    chk_tgt(28'h00c8000, BMD_TGT_ADAPTER);
    chk_tgt(28'h00dfffc, BMD_TGT_ADAPTER);
    chk_tgt(28'h0fe0000, BMD_TGT_ROM);
    av_go(4'hf, 1'b1, 32'hffffffff);
    av_go(4'hf, 1'b0, 32'h0);
    `CHK("unmapped read", UNMAPPED_VAL, rd)
    av_go(REG_SHADOW, 1'b1, 32'h00000001);
    av_go(REG_SHADOW, 1'b0, 32'h0);
    `CHK("shadow reg", 32'h00000001, rd)
    mem_go(28'h00e0100, 1'b0, 32'h0);
    `CHK("shadow uncached", 1'b0, m_cac)
    mem_go(28'h0200100, 1'b0, 32'h0);
    `CHK("dram cached", 1'b1, m_cac)
  endtask

  task t_map_b();
    do_reset(2'h3, 1'b0, 2'h1, 1'b1, 2'h1, 2'h3);
    av_go(REG_CONFIG, 1'b0, 32'h0);
    `CHK("config fast static", 32'h00000016, rd)
    chk_tgt(28'h07ffffc, BMD_TGT_BANK0);
    chk_tgt(28'h0800000, BMD_TGT_SLOT0);
    chk_tgt(28'h0bffffc, BMD_TGT_SLOT0);
    chk_tgt(28'h0c00000, BMD_TGT_SLOT1);
    chk_tgt(28'h1bffffc, BMD_TGT_SLOT1);
  endtask

  task t_totals();
    logic [27:0] top;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], 1'b0, 2'h0, 1'b0, 2'h0, 2'h0);
      top = 28'h0100000 << i;
      chk_tgt(top >> 1, BMD_TGT_BANK0);
      chk_tgt(top, BMD_TGT_ISA);
    end
  endtask

  task t_modes();
    bmd_acc_t ex[4];
    ex = '{BMD_ACC_FAST_PAGE, BMD_ACC_STATIC_COL, BMD_ACC_RAS_CAS,
           BMD_ACC_FAST_PAGE};
    for (int m = 0; m < 4; m++) begin
      do_reset(2'h0, 1'b0, m[1:0], 1'b0, 2'h0, 2'h0);
      mem_go(28'h0000040, 1'b0, 32'h0);
      mem_go(28'h0000044, 1'b0, 32'h0);
      `CHK("page hit access", ex[m], m_acc)
      mem_go(28'h0001000, 1'b0, 32'h0);
      `CHK("page miss access", BMD_ACC_RAS_CAS, m_acc)
    end
  endtask

  task t_parity();
    mem_go(28'h0000010, 1'b1, 32'ha5c31e70);
    mem_go(28'h0000014, 1'b1, 32'h5a3ce18f);
    mem_go(28'h0000010, 1'b0, 32'h0);
    `CHK("read back", 32'ha5c31e70, m_rd)
    `CHK("parity flag", 1'b0, m_pe)
  endtask

  task ref_wait(output int n);
    n = 0;
    while (ref_act === 1'b1) @(negedge core_clk);
    while (ref_act !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task ref_len(output int h);
    h = 0;
    while (ref_act === 1'b1 && h < 50) begin
      @(negedge core_clk);
      h++;
    end
  endtask

  task t_refresh();
    int n, h;
    ref_wait(n);
    ref_len(h);
    `CHK("refresh length", REF_HOLD_CYC, h)
    r0 = refresh_addr;
    ref_wait(n);
    `CHK("refresh spacing", 1'b1, (n + h >= REF - 2 && n + h <= REF + 2))
    ref_len(h);
    `CHK("refresh row", r0 + 8'h01, refresh_addr)
  endtask

  task t_master();
    int n, rises;
    logic prev;
    rises = 0;
    prev = 1'b0;
    @(posedge core_clk);
    take_bus <= 1'b1;
    for (n = 0; n < 120; n++) begin
      @(negedge core_clk);
      if (ref_act === 1'b1) begin
        `CHK("grant in refresh", 1'b0, grant)
      end
      if (ref_act === 1'b1 && prev !== 1'b1)
        rises++;
      prev = ref_act;
    end
    `CHK("master refreshes", 1'b1, rises >= 3)
    while (ref_act === 1'b1) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    `CHK("grant back", 1'b1, grant)
    @(posedge core_clk);
    take_bus <= 1'b0;
  endtask

  initial begin
    arst_n = 1'b0; tot = 2'h0; two = 1'b0; mode = 2'h0; fast = 1'b0;
    s0 = 2'h0; s1 = 2'h0; mem_req = 1'b0; mem_we = 1'b0;
    mem_addr = 28'h0; mem_wdata = 32'h0; cache_hit = 1'b0;
    take_bus = 1'b0; avs_address = 4'h0; avs_read = 1'b0;
    avs_write = 1'b0; avs_writedata = 32'h0;
    t_map_a();
    t_map_b();
    t_totals();
    t_modes();
    t_parity();
    t_refresh();
    t_master();
    end_of_test();
  end

  // Covers ten resets, two refresh spans and the master window
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end
endmodule
